/* File: core/hpspl_pkg.sv */
// Package for the hub port strap and power logic
// Notes on behaviour
// - Pull-up only after upstream power detected
// - Sample disable straps at reset release
// - Port off only when both pins high
// - Port power enables drive active high
// - Suffix _n means asserted low
// - Latch config select at reset release
package hpspl_pkg;
    localparam int NUM_PORTS = 4;
    localparam logic [NUM_PORTS-1:0] PORTS_NONE = 4'h0;
    localparam logic [NUM_PORTS-1:0] PORTS_ALL  = 4'hF;
    localparam logic SYNC_IDLE = 1'b0;

    typedef enum {
        HPSPL_IN_RESET,
        HPSPL_SAMPLE,
        HPSPL_RUN
    } hpspl_state_t;

    typedef struct packed {
        logic [NUM_PORTS-1:0] plus;
        logic [NUM_PORTS-1:0] minus;
    } hpspl_pins_t;
endpackage

/* File: core/hpspl_sync.sv */
// Two-flop synchroniser, one lane per bit
`timescale 1ns/100ps
`default_nettype none
module hpspl_sync
    import hpspl_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output var  logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_r;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_lane
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    stage1_r[i] <= SYNC_IDLE;
                    syncOut[i]  <= SYNC_IDLE;
                end else begin
                    stage1_r[i] <= asyncIn[i];
                    syncOut[i]  <= stage1_r[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* File: core/hpspl_top.sv */
// Upstream connect, port-disable straps and port power enables
`timescale 1ns/100ps
`default_nettype none
module hpspl_top
    import hpspl_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 upstreamPowerDetect,
    input  wire logic                 strapEnable,
    input  wire logic                 configMethodSelect0,
    input  wire logic [NUM_PORTS-1:0] downstreamDataPlus,
    input  wire logic [NUM_PORTS-1:0] downstreamDataMinus,
    input  wire logic [NUM_PORTS-1:0] portPowerRequest,
    input  wire logic [NUM_PORTS-1:0] overCurrentSense_n,
    output logic                      upstreamPullupEnable,
    output logic [NUM_PORTS-1:0]      portPowerEnable,
    output logic [NUM_PORTS-1:0]      portDisabled,
    output logic [NUM_PORTS-1:0]      overCurrent,
    output logic                      configMethod,
    output logic                      strapValid
);
    localparam int SYNC_W = 2 * NUM_PORTS + NUM_PORTS + 2;

    hpspl_pins_t          pinsSync;
    logic [NUM_PORTS-1:0] ocSync;
    logic                 powerSync;
    logic                 cfgSync;
    logic [SYNC_W-1:0]    syncIn;
    logic [SYNC_W-1:0]    syncOut;

    hpspl_state_t         state_r;
    hpspl_state_t         state_nxt;
    logic [NUM_PORTS-1:0] portDisabled_nxt;
    logic [NUM_PORTS-1:0] overCurrent_nxt;
    logic [NUM_PORTS-1:0] bothHigh;
    logic                 sampleNow;

    // Pins come from outside the clock domain
    // Sense inverted first: sync reset level then means no fault
    assign syncIn = {downstreamDataPlus, downstreamDataMinus,
                     ~overCurrentSense_n, upstreamPowerDetect,
                     configMethodSelect0};

    hpspl_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn (syncIn),
        .syncOut (syncOut)
    );

    assign pinsSync  = syncOut[SYNC_W-1 -: 2*NUM_PORTS];
    assign ocSync    = syncOut[NUM_PORTS+1 -: NUM_PORTS];
    assign powerSync = syncOut[1];
    assign cfgSync   = syncOut[0];

    // Sync second stage holds pin levels only from the second edge
    assign sampleNow = (state_r == HPSPL_RUN) && !strapValid;

    // Disable needs both data pins tied high
    assign bothHigh = pinsSync.plus & pinsSync.minus;

    assign portDisabled_nxt = sampleNow
                            ? (strapEnable ? bothHigh : PORTS_NONE)
                            : portDisabled;

    // Over-current sense asserted at the low level
    assign overCurrent_nxt = ocSync;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            HPSPL_IN_RESET: state_nxt = HPSPL_SAMPLE;
            HPSPL_SAMPLE:   state_nxt = HPSPL_RUN;
            HPSPL_RUN:      state_nxt = HPSPL_RUN;
        endcase
    end

    // Sampling waits two edges so the synchronisers hold pin levels
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= HPSPL_IN_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            portDisabled <= PORTS_NONE;
            strapValid   <= 1'b0;
            configMethod <= 1'b0;
        end else begin
            portDisabled <= portDisabled_nxt;
            strapValid   <= strapValid | sampleNow;
            if (sampleNow) begin
                configMethod <= cfgSync;
            end
        end
    end

    // Power and pull-up held off until straps are settled
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            upstreamPullupEnable <= 1'b0;
            portPowerEnable      <= PORTS_NONE;
            overCurrent          <= PORTS_NONE;
        end else begin
            upstreamPullupEnable <= powerSync & strapValid;
            portPowerEnable      <= strapValid
                                  ? (portPowerRequest & ~portDisabled)
                                  : PORTS_NONE;
            overCurrent          <= overCurrent_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: dv/hpspl_properties.sv */
// Checker for the hub strap and power logic
`timescale 1ns/100ps
`default_nettype none
module hpspl_properties
    import hpspl_pkg::*;
(
    input wire logic                 sys_clk,
    input wire logic                 rst,
    input wire logic                 upstreamPowerDetect,
    input wire logic                 strapEnable,
    input wire logic                 configMethodSelect0,
    input wire logic [NUM_PORTS-1:0] downstreamDataPlus,
    input wire logic [NUM_PORTS-1:0] downstreamDataMinus,
    input wire logic [NUM_PORTS-1:0] portPowerRequest,
    input wire logic [NUM_PORTS-1:0] overCurrentSense_n,
    input wire logic                 upstreamPullupEnable,
    input wire logic [NUM_PORTS-1:0] portPowerEnable,
    input wire logic [NUM_PORTS-1:0] portDisabled,
    input wire logic [NUM_PORTS-1:0] overCurrent,
    input wire logic                 configMethod,
    input wire logic                 strapValid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Sync pipes plus output flops delay pin levels by three edges
    sequence s_settled; strapValid && $past(strapValid, 3); endsequence
    property p_pull; s_settled |-> upstreamPullupEnable ==
        $past(upstreamPowerDetect, 3); endproperty
    a_pull: assert property (p_pull) else $error("pull-up");
    property p_pre; !$past(strapValid) |-> !upstreamPullupEnable &&
        portPowerEnable == PORTS_NONE; endproperty
    a_pre: assert property (p_pre) else $error("early on");
    property p_pwr; $past(strapValid) |-> portPowerEnable ==
        ($past(portPowerRequest) & ~$past(portDisabled)); endproperty
    a_pwr: assert property (p_pwr) else $error("power");
    property p_oc; s_settled |-> overCurrent ==
        ~$past(overCurrentSense_n, 3); endproperty
    a_oc: assert property (p_oc) else $error("over-current");
    property p_strap; $rose(strapValid) |-> portDisabled ==
        ($past(downstreamDataPlus, 3) & $past(downstreamDataMinus, 3)
        & {NUM_PORTS{$past(strapEnable)}}); endproperty
    a_strap: assert property (p_strap) else $error("strap");
    property p_cfg; $rose(strapValid) |-> configMethod ==
        $past(configMethodSelect0, 3); endproperty
    a_cfg: assert property (p_cfg) else $error("config");
    property p_hold; $past(strapValid) |-> $stable(portDisabled) &&
        $stable(configMethod); endproperty
    a_hold: assert property (p_hold) else $error("held");
endmodule
bind hpspl_top hpspl_properties hpspl_properties_i (.*);
`default_nettype wire

/* File: dv/hpspl_partner.sv */
// Far side: strap ties, then bus activity
`timescale 1ns/100ps
`default_nettype none
module hpspl_partner
    import hpspl_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        busy,
    input  wire hpspl_pins_t strap,
    output hpspl_pins_t      pins
);
    // Toggling traffic while busy, else the strap value held
    always_ff @(posedge sys_clk) pins <= busy ? ~pins : strap;
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Testbench for the hub strap and power logic
`timescale 1ns/100ps
`default_nettype none
module tb;
    import hpspl_pkg::*;
    logic sys_clk, rst, upstreamPowerDetect, strapEnable, busy;
    logic configMethodSelect0, upstreamPullupEnable, configMethod, strapValid;
    logic [3:0] portPowerRequest, overCurrentSense_n, portPowerEnable;
    logic [3:0] portDisabled, overCurrent, downstreamDataPlus;
    logic [3:0] downstreamDataMinus;
    hpspl_pins_t strap, pins;
    int miscompares = 0, checks_done = 0;
    assign downstreamDataPlus = pins.plus;
    assign downstreamDataMinus = pins.minus;
    hpspl_top hpspl_top_i (.*);
    hpspl_partner hpspl_partner_i (.*);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic check(string nm, logic [3:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("mismatches %0d checks %0d", miscompares, checks_done);
        if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic strap_case(hpspl_pins_t s, logic en, cfg);
        int n;
        n = 0;
        strap = s;
        strapEnable = en;
        configMethodSelect0 = cfg;
        busy = 1'b0;
        rst = 1'b1;
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        while (strapValid !== 1'b1 && n < 8) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 8) begin
            miscompares++;
            stop_test();
        end
        check("disabled", portDisabled, en ? s.plus & s.minus : 4'h0);
        check("config", {3'h0, configMethod}, {3'h0, cfg});
    endtask
    // Traffic on the data pins must not move the straps
    task automatic run_case(logic [3:0] dis);
        busy = 1'b1;
        portPowerRequest = 4'hF;
        upstreamPowerDetect = 1'b1;
        overCurrentSense_n = 4'h6;
        repeat (5) @(negedge sys_clk);
        check("power", portPowerEnable, ~dis);
        check("pullup", {3'h0, upstreamPullupEnable}, 4'h1);
        check("overcurrent", overCurrent, 4'h9);
        check("held", portDisabled, dis);
    endtask
    initial begin
        upstreamPowerDetect = 1'b0;
        portPowerRequest = 4'h0;
        overCurrentSense_n = 4'hF;
        strap_case('{plus: 4'hF, minus: 4'h5}, 1'b1, 1'b1);
        run_case(4'h5);
        strap_case('{plus: 4'hF, minus: 4'hF}, 1'b0, 1'b0);
        run_case(4'h0);
        stop_test();
    end
endmodule
`default_nettype wire
